// ===== design/rta_pkg.sv
package rta_pkg;

  // ----------------------------------------------------------------
  // Widths
  // ----------------------------------------------------------------
  localparam int PRE_W = 6;
  localparam int PRE_DIV = 64;
  localparam int DIV_W = 20;
  localparam int CNT_W = 32;
  localparam int CYC_W = 16;
  localparam int EVT_W = 3;
  localparam int ADDR_W = 4;

  // ----------------------------------------------------------------
  // Register word indexes (byte address = 4 * index)
  // ----------------------------------------------------------------
  localparam logic [ADDR_W-1:0] REG_CTRL = 4'h0;
  localparam logic [ADDR_W-1:0] REG_PERIOD = 4'h1;
  localparam logic [ADDR_W-1:0] REG_DIVIDER = 4'h2;
  localparam logic [ADDR_W-1:0] REG_COUNT = 4'h3;
  localparam logic [ADDR_W-1:0] REG_ALARM = 4'h4;
  localparam logic [ADDR_W-1:0] REG_CYCLE = 4'h5;
  localparam logic [ADDR_W-1:0] REG_STATUS = 4'h6;
  localparam logic [ADDR_W-1:0] REG_CLEAR = 4'h7;
  localparam logic [ADDR_W-1:0] REG_ENABLE = 4'h8;
  localparam logic [ADDR_W-1:0] REG_SYSSTAT = 4'h9;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int CTRL_EN = 0;
  localparam int CTRL_OSCOFF = 1;
  localparam int CTRL_RUNLP = 2;
  localparam int CTRL_PDWAKE = 3;
  localparam int CTRL_W = 4;
  localparam int EVT_TICK = 0;
  localparam int EVT_CYCLE = 1;
  localparam int EVT_ALARM = 2;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [CTRL_W-1:0] CTRL_RST = 4'h0;
  localparam logic [31:0] PERIOD_RST = 32'h0000_0000;
  localparam logic [31:0] WORD_ZERO = 32'h0000_0000;

  // ----------------------------------------------------------------
  // Oscillator selection after reset
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    SEL_SYNC1 = 2'h0,
    SEL_SYNC2 = 2'h1,
    SEL_LATCH = 2'h3,
    SEL_DONE = 2'h2
  } rta_sel_type;

endpackage : rta_pkg

// ===== design/rta_sync.sv
`timescale 1ns/1ns
module rta_sync (
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic din,
  output logic dout
);

  logic meta;

  // ----------------------------------------------------------------
  // Two-stage synchroniser
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      meta <= 1'b0;
      dout <= 1'b0;
    end else begin
      meta <= din;
      dout <= meta;
    end
  end

endmodule : rta_sync

// ===== design/rta_prescale.sv
`timescale 1ns/1ns
module rta_prescale #(
  parameter int W = rta_pkg::PRE_W
) (
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic run,
  output logic [W-1:0] phase,
  output logic pulse
);

  if (W < 1) begin : g_chk
    $error("rta_prescale: width must be at least one");
  end

  // ----------------------------------------------------------------
  // Fixed divide stage
  // ----------------------------------------------------------------
  wire wrap = run && (phase == {W{1'b1}});

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      phase <= '0;
      pulse <= 1'b0;
    end else begin
      if (run) begin
        phase <= phase + W'(1);
      end
      pulse <= wrap;
    end
  end

endmodule : rta_prescale

// ===== design/rta_core.sv
`timescale 1ns/1ns
module rta_core #(
  parameter int DIV_W = rta_pkg::DIV_W,
  parameter int CNT_W = rta_pkg::CNT_W,
  parameter int CYC_W = rta_pkg::CYC_W
) (
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic [rta_pkg::ADDR_W-1:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  output logic [31:0] readdata,
  output logic waitrequest,
  input wire logic idleMode,
  input wire logic powerdownMode,
  input wire logic lpOscPresent,
  output logic irq,
  output logic tickReq,
  output logic cycleReq,
  output logic alarmReq,
  output logic wakeReq,
  output logic mainOscOff,
  output logic lpOscOff,
  output logic lowPowerSel
);

  localparam int EW = rta_pkg::EVT_W;

  if (DIV_W + rta_pkg::PRE_W > 32 || DIV_W < 1) begin : g_chk_div
    $error("rta_core: divider width out of range");
  end
  if (CNT_W > 32 || CNT_W < 1 || CYC_W > 32 || CYC_W < 1) begin : g_chk_cnt
    $error("rta_core: counter width out of range");
  end

  function automatic logic hit(
    input logic [rta_pkg::ADDR_W-1:0] a,
    input logic [rta_pkg::ADDR_W-1:0] idx
  );
    hit = (a == idx);
  endfunction : hit

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  logic [rta_pkg::CTRL_W-1:0] ctrl;
  logic [DIV_W-1:0] period;
  logic [DIV_W-1:0] div;
  logic [CNT_W-1:0] count;
  logic [CNT_W-1:0] alarm;
  logic [CYC_W-1:0] cycN;
  logic [CYC_W-1:0] cycCnt;
  logic [EW-1:0] status;
  logic [EW-1:0] irqEn;
  rta_pkg::rta_sel_type selState;
  logic [rta_pkg::PRE_W-1:0] prePhase;
  logic prePulse;
  logic lpDet;

  // ----------------------------------------------------------------
  // Bus decode
  // ----------------------------------------------------------------
  // Two-cycle answer: read data fetched at the first edge, write
  // applied at the edge where the master sees waitrequest low.
  wire rdTake = read && waitrequest;
  wire wrDo = write && !waitrequest;
  wire wrCtrl = wrDo && hit(address, rta_pkg::REG_CTRL);
  wire wrPeriod = wrDo && hit(address, rta_pkg::REG_PERIOD);
  wire wrCount = wrDo && hit(address, rta_pkg::REG_COUNT);
  wire wrAlarm = wrDo && hit(address, rta_pkg::REG_ALARM);
  wire wrCycle = wrDo && hit(address, rta_pkg::REG_CYCLE);
  wire wrClear = wrDo && hit(address, rta_pkg::REG_CLEAR);
  wire wrEnable = wrDo && hit(address, rta_pkg::REG_ENABLE);

  // ----------------------------------------------------------------
  // Counting chain
  // ----------------------------------------------------------------
  wire lowPwr = idleMode || powerdownMode;
  wire pdOscStop = powerdownMode && ctrl[rta_pkg::CTRL_OSCOFF];
  wire countRun = ctrl[rta_pkg::CTRL_EN]
                  && (!lowPwr || ctrl[rta_pkg::CTRL_RUNLP]) && !pdOscStop;
  wire divZero = (div == '0);
  wire tick = prePulse && countRun && divZero;
  wire [CNT_W-1:0] countInc = count + CNT_W'(1);
  wire [CYC_W-1:0] cycInc = cycCnt + CYC_W'(1);
  wire cycHit = tick && (cycN != '0) && (cycInc == cycN);
  wire alarmHit = tick && !wrCount && (countInc == alarm);
  wire [EW-1:0] evt = {alarmHit, cycHit, tick};

  wire [DIV_W-1:0] next_div = divZero ? period : div - DIV_W'(1);
  wire [CNT_W-1:0] next_count = wrCount ? writedata[CNT_W-1:0]
                              : tick ? countInc : count;
  // Restart on a new n and park while off, so a stale count never skips a hit
  wire cycRestart = wrCycle || (cycN == '0);
  wire [CYC_W-1:0] next_cycCnt = cycRestart ? '0
                               : (!tick) ? cycCnt
                               : cycHit ? '0 : cycInc;

  // ----------------------------------------------------------------
  // Flags and interrupt
  // ----------------------------------------------------------------
  wire [EW-1:0] clrMask = wrClear ? writedata[EW-1:0] : '0;
  // Hardware set wins over a simultaneous software clear
  wire [EW-1:0] next_status = (status & ~clrMask) | evt;
  wire anyPend = |(status & irqEn);

  // ----------------------------------------------------------------
  // Oscillator control
  // ----------------------------------------------------------------
  wire blockOn = ctrl[rta_pkg::CTRL_EN];
  wire next_mainOscOff = powerdownMode
       && (lowPowerSel || !blockOn || ctrl[rta_pkg::CTRL_OSCOFF]);
  wire next_lpOscOff = powerdownMode
       && (!blockOn || (ctrl[rta_pkg::CTRL_OSCOFF] && lowPowerSel));
  wire next_wakeReq = powerdownMode && ctrl[rta_pkg::CTRL_PDWAKE]
                      && |(evt & irqEn);

  // ----------------------------------------------------------------
  // Read selection
  // ----------------------------------------------------------------
  // Divider word plus counter word give the 58-bit long timer
  wire [31:0] divWord = 32'({prePhase, div});
  wire [31:0] sysWord = 32'({powerdownMode, lpOscOff, mainOscOff, lowPowerSel,
                             selState == rta_pkg::SEL_DONE});
  wire [31:0] rdMux =
      hit(address, rta_pkg::REG_CTRL) ? 32'(ctrl) :
      hit(address, rta_pkg::REG_PERIOD) ? 32'(period) :
      hit(address, rta_pkg::REG_DIVIDER) ? divWord :
      hit(address, rta_pkg::REG_COUNT) ? 32'(count) :
      hit(address, rta_pkg::REG_ALARM) ? 32'(alarm) :
      hit(address, rta_pkg::REG_CYCLE) ? 32'(cycN) :
      hit(address, rta_pkg::REG_STATUS) ? 32'(status) :
      hit(address, rta_pkg::REG_ENABLE) ? 32'(irqEn) :
      hit(address, rta_pkg::REG_SYSSTAT) ? sysWord :
      rta_pkg::WORD_ZERO;

  // ----------------------------------------------------------------
  // Sub-blocks
  // ----------------------------------------------------------------
  rta_prescale #(
    .W(rta_pkg::PRE_W)
  ) u_pre (
    .core_clk(core_clk),
    .sys_rst(sys_rst),
    .run(countRun),
    .phase(prePhase),
    .pulse(prePulse)
  );

  rta_sync u_sync (
    .core_clk(core_clk),
    .sys_rst(sys_rst),
    .din(lpOscPresent),
    .dout(lpDet)
  );

  // ----------------------------------------------------------------
  // Bus slave
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      waitrequest <= 1'b1;
      readdata <= rta_pkg::WORD_ZERO;
    end else begin
      waitrequest <= !((read || write) && waitrequest);
      if (rdTake) begin
        readdata <= rdMux;
      end
    end
  end

  // ----------------------------------------------------------------
  // Software registers
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      ctrl <= rta_pkg::CTRL_RST;
      period <= rta_pkg::PERIOD_RST[DIV_W-1:0];
      alarm <= '0;
      cycN <= '0;
      irqEn <= '0;
    end else begin
      if (wrCtrl) ctrl <= writedata[rta_pkg::CTRL_W-1:0];
      if (wrPeriod) period <= writedata[DIV_W-1:0];
      if (wrAlarm) alarm <= writedata[CNT_W-1:0];
      if (wrCycle) cycN <= writedata[CYC_W-1:0];
      if (wrEnable) irqEn <= writedata[EW-1:0];
    end
  end

  // ----------------------------------------------------------------
  // Divider, counter, cycle counter
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      div <= '0;
      count <= '0;
      cycCnt <= '0;
    end else begin
      if (prePulse && countRun) div <= next_div;
      count <= next_count;
      cycCnt <= next_cycCnt;
    end
  end

  // ----------------------------------------------------------------
  // Events and requests
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      status <= '0;
      irq <= 1'b0;
      tickReq <= 1'b0;
      cycleReq <= 1'b0;
      alarmReq <= 1'b0;
      wakeReq <= 1'b0;
    end else begin
      status <= next_status;
      irq <= anyPend;
      tickReq <= tick && irqEn[rta_pkg::EVT_TICK];
      cycleReq <= cycHit && irqEn[rta_pkg::EVT_CYCLE];
      alarmReq <= alarmHit && irqEn[rta_pkg::EVT_ALARM];
      wakeReq <= next_wakeReq;
    end
  end

  // ----------------------------------------------------------------
  // Oscillator selection and shutdown
  // ----------------------------------------------------------------
  // Detect pin is sampled only after the synchroniser has filled
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      selState <= rta_pkg::SEL_SYNC1;
      lowPowerSel <= 1'b0;
      mainOscOff <= 1'b0;
      lpOscOff <= 1'b0;
    end else begin
      unique case (selState)
        rta_pkg::SEL_SYNC1: selState <= rta_pkg::SEL_SYNC2;
        rta_pkg::SEL_SYNC2: selState <= rta_pkg::SEL_LATCH;
        rta_pkg::SEL_LATCH: begin
          lowPowerSel <= lpDet;
          selState <= rta_pkg::SEL_DONE;
        end
        rta_pkg::SEL_DONE: selState <= rta_pkg::SEL_DONE;
      endcase
      mainOscOff <= next_mainOscOff;
      lpOscOff <= next_lpOscOff;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (sys_rst);

  sequence seq_req_taken;
    (read || write) && waitrequest;
  endsequence

  sequence seq_answer;
    !waitrequest ##1 waitrequest;
  endsequence

  chk_bus_answer: assert property (
    seq_req_taken |=> seq_answer)
    else $error("bus answer not after one wait cycle");

  chk_pre_spacing: assert property (
    prePulse |=> !prePulse [*8])
    else $error("prescale pulses too close");

  chk_div_reload: assert property (
    prePulse && countRun && divZero |=> div == $past(period))
    else $error("divider not reloaded from period");

  chk_count_step: assert property (
    tick && !wrCount |=> count == $past(count) + CNT_W'(1))
    else $error("counter did not step on tick");

  chk_alarm_flag: assert property (
    tick && !wrCount && countInc == alarm |=> status[rta_pkg::EVT_ALARM])
    else $error("alarm flag not raised on match");

  chk_sticky_flag: assert property (
    status[rta_pkg::EVT_TICK] && !(wrClear && writedata[rta_pkg::EVT_TICK])
    |=> status[rta_pkg::EVT_TICK])
    else $error("tick flag dropped without clear");

  chk_irq_level: assert property (
    anyPend |=> irq)
    else $error("interrupt not raised for enabled flag");

  chk_tick_req: assert property (
    tickReq |-> $past(tick) && $past(irqEn[rta_pkg::EVT_TICK]))
    else $error("tick request without enabled tick");

  chk_main_keep: assert property (
    powerdownMode && !lowPowerSel && blockOn && !ctrl[rta_pkg::CTRL_OSCOFF]
    |=> !mainOscOff)
    else $error("main oscillator stopped while clocking counter");

  chk_lp_main_off: assert property (
    powerdownMode && lowPowerSel |=> mainOscOff)
    else $error("main oscillator kept in power down");

  chk_full_stop: assert property (
    powerdownMode && !blockOn |=> mainOscOff && lpOscOff)
    else $error("oscillators kept while block disabled");

  chk_lp_hold: assert property (
    idleMode && !ctrl[rta_pkg::CTRL_RUNLP] |-> !countRun)
    else $error("counter ran in idle without permission");

  chk_cyc_bound: assert property (
    cycN != '0 |-> cycCnt < cycN)
    else $error("cyclic count passed its limit");

  chk_osc_pick: assert property (
    selState == rta_pkg::SEL_LATCH |=> lowPowerSel == $past(lpDet))
    else $error("oscillator pick not taken from detector");

endmodule : rta_core

// ===== tb/rtc_timekeeper_alarm_tb_top.sv
`timescale 1ns/1ns
module rtc_timekeeper_alarm_tb_top;
  // ----------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------
  logic core_clk, sys_rst, read, write, idleMode, powerdownMode, lpOscPresent;
  logic [rta_pkg::ADDR_W-1:0] address;
  logic [31:0] writedata, readdata, rd, rd2, v;
  logic waitrequest, irq, tickReq, cycleReq, alarmReq, wakeReq;
  logic mainOscOff, lpOscOff, lowPowerSel, lpv;
  int errors, checks, n, p, k, nc, seedDummy;
  logic [3:0] idx[4] = '{4'h1, 4'h4, 4'h5, 4'h8};
  logic [31:0] msk[4] = '{32'h000F_FFFF, 32'hFFFF_FFFF, 32'h0000_FFFF, 32'h0000_0007};

  rta_core dut (.core_clk(core_clk), .sys_rst(sys_rst), .address(address), .read(read),
    .write(write), .writedata(writedata), .readdata(readdata), .waitrequest(waitrequest),
    .idleMode(idleMode), .powerdownMode(powerdownMode), .lpOscPresent(lpOscPresent),
    .irq(irq), .tickReq(tickReq), .cycleReq(cycleReq), .alarmReq(alarmReq),
    .wakeReq(wakeReq), .mainOscOff(mainOscOff), .lpOscOff(lpOscOff),
    .lowPowerSel(lowPowerSel));

  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic f_main(input int c, input logic lp);
    return lp | !c[rta_pkg::CTRL_EN] | c[rta_pkg::CTRL_OSCOFF];
  endfunction : f_main

  function automatic logic f_lpo(input int c, input logic lp);
    return !c[rta_pkg::CTRL_EN] | (c[rta_pkg::CTRL_OSCOFF] & lp);
  endfunction : f_lpo

  task automatic check(input logic [31:0] got, input logic [31:0] exp, input string msg);
    checks++;
    if (got !== exp) begin
      errors++;
      $display("Error t=%0t %s got %h exp %h", $time, msg, got, exp);
    end
  endtask : check

  // Request held until waitrequest is sampled low
  task automatic bus(input logic wr, input logic [3:0] adr, input logic [31:0] wd,
                     output logic [31:0] dat);
    int w;
    @(posedge core_clk);
    address <= adr;
    writedata <= wd;
    read <= !wr;
    write <= wr;
    w = 0;
    do begin
      @(posedge core_clk);
      w++;
    end while (waitrequest !== 1'b0 && w < 50);
    if (w >= 50) check(32'h1, 32'h0, "bus timeout");
    dat = readdata;
    read <= 1'b0;
    write <= 1'b0;
  endtask : bus

  task automatic wreg(input logic [3:0] adr, input logic [31:0] wd);
    logic [31:0] d;
    bus(1'b1, adr, wd, d);
  endtask : wreg

  task automatic rreg(input logic [3:0] adr, output logic [31:0] d);
    bus(1'b0, adr, 32'h0000_0000, d);
  endtask : rreg

  // Returns the edge count at which the pulse is seen, -1 if never
  task automatic wait_evt(input int which, input int lim, output int cnt);
    logic s;
    cnt = -1;
    for (int i = 1; i <= lim; i++) begin
      @(posedge core_clk);
      s = (which == 0) ? tickReq : (which == 1) ? cycleReq : (which == 2) ? alarmReq : wakeReq;
      if (s === 1'b1) begin
        cnt = i;
        break;
      end
    end
  endtask : wait_evt

  task automatic complete_run;
    $display("Counts: checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : complete_run

  // ----------------------------------------------------------------
  // Watchdog, well beyond the few thousand cycles the tests need
  // ----------------------------------------------------------------
  initial begin
    #600000;
    errors++;
    $display("Error t=%0t watchdog expired", $time);
    complete_run();
  end

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    sys_rst = 1'b1;
    read = 1'b0;
    write = 1'b0;
    address = 4'h0;
    writedata = 32'h0000_0000;
    idleMode = 1'b0;
    powerdownMode = 1'b0;
    lpOscPresent = 1'b0;
    seedDummy = $urandom(32'he534cf47);
    // Both oscillator selections, each from its own reset
    for (int pass = 0; pass < 2; pass++) begin
      lpv = (pass == 1);
      sys_rst <= 1'b1;
      lpOscPresent <= lpv;
      repeat (20) @(posedge core_clk);
      sys_rst <= 1'b0;
      repeat (5) @(posedge core_clk);
      check({31'h0, waitrequest}, 32'h1, "idle waitrequest");
      check({31'h0, irq}, 32'h0, "irq after reset");
      check({31'h0, lowPowerSel}, {31'h0, lpv}, "oscillator pick");
      rreg(rta_pkg::REG_SYSSTAT, rd);
      check(rd, {30'h0, lpv, 1'b1}, "sysstat");
      for (k = 0; k < 9; k++) begin
        rreg(k[3:0], rd);
        check(rd, 32'h0000_0000, "reset value");
      end
      wreg(rta_pkg::REG_STATUS, 32'h0000_0007);
      wreg(rta_pkg::REG_DIVIDER, 32'hFFFF_FFFF);
      wreg(4'hC, 32'hFFFF_FFFF);
      rreg(rta_pkg::REG_STATUS, rd);
      check(rd, 32'h0000_0000, "status write ignored");
      rreg(rta_pkg::REG_DIVIDER, rd);
      check(rd, 32'h0000_0000, "divider write ignored");
      rreg(4'hC, rd);
      check(rd, 32'h0000_0000, "unmapped read");
      // Oscillator requests for every control setting in power down
      powerdownMode <= 1'b1;
      for (k = 0; k < 16; k++) begin
        wreg(rta_pkg::REG_CTRL, k);
        repeat (3) @(posedge core_clk);
        check({30'h0, mainOscOff, lpOscOff}, {30'h0, f_main(k, lpv), f_lpo(k, lpv)},
              "oscillator off");
      end
      powerdownMode <= 1'b0;
      wreg(rta_pkg::REG_CTRL, 32'h0000_0000);
      repeat (3) @(posedge core_clk);
      check({30'h0, mainOscOff, lpOscOff}, 32'h0, "oscillators run");
      $display("Test reset and oscillators pass %0d done", pass);
    end
    // Read back with field masks
    for (k = 0; k < 4; k++) begin
      v = $urandom;
      wreg(idx[k], v);
      rreg(idx[k], rd);
      check(rd, v & msk[k], "readback");
    end
    v = $urandom;
    wreg(rta_pkg::REG_CTRL, v);
    rreg(rta_pkg::REG_CTRL, rd);
    check(rd, v & 32'h0000_000F, "ctrl readback");
    rreg(rta_pkg::REG_CLEAR, rd);
    check(rd, 32'h0000_0000, "clear reads zero");
    $display("Test registers done");
    // Tick period and counter
    wreg(rta_pkg::REG_CTRL, 32'h0000_0000);
    wreg(rta_pkg::REG_CYCLE, 32'h0000_0000);
    wreg(rta_pkg::REG_ENABLE, 32'h0000_0000);
    p = $urandom_range(3, 0);
    wreg(rta_pkg::REG_PERIOD, p);
    wreg(rta_pkg::REG_COUNT, 32'h0000_0000);
    wreg(rta_pkg::REG_CTRL, 32'h0000_0001);
    wreg(rta_pkg::REG_ENABLE, 32'h0000_0001);
    wait_evt(0, 2000, n);
    wait_evt(0, 2000, n);
    check(n, (p + 1) * rta_pkg::PRE_DIV, "tick period");
    check({31'h0, irq}, 32'h1, "tick irq");
    rreg(rta_pkg::REG_COUNT, rd);
    wait_evt(0, 2000, n);
    rreg(rta_pkg::REG_COUNT, rd2);
    check(rd2, rd + 1, "count step");
    rreg(rta_pkg::REG_DIVIDER, rd);
    check({6'h0, rd[31:26], 19'h0, rd[19:0] <= p}, 32'h1, "divider chain");
    wreg(rta_pkg::REG_ENABLE, 32'h0000_0000);
    repeat (2) @(posedge core_clk);
    check({31'h0, irq}, 32'h0, "masked irq");
    rreg(rta_pkg::REG_STATUS, rd);
    check(rd & 32'h0000_0001, 32'h1, "tick flag sticky");
    $display("Test tick done");
    // Alarm on the second tick after preload
    wreg(rta_pkg::REG_PERIOD, 32'h0000_0003);
    v = $urandom;
    wreg(rta_pkg::REG_ALARM, v + 2);
    wreg(rta_pkg::REG_COUNT, v);
    wreg(rta_pkg::REG_CLEAR, 32'h0000_0007);
    wreg(rta_pkg::REG_ENABLE, 32'h0000_0004);
    wait_evt(2, 1000, n);
    check({31'h0, n > 200}, 32'h1, "alarm moment");
    rreg(rta_pkg::REG_COUNT, rd);
    check(rd, v + 2, "alarm count");
    check({31'h0, irq}, 32'h1, "alarm irq");
    wreg(rta_pkg::REG_CLEAR, 32'h0000_0004);
    repeat (2) @(posedge core_clk);
    check({31'h0, irq}, 32'h0, "irq cleared");
    rreg(rta_pkg::REG_STATUS, rd);
    check(rd & 32'h0000_0004, 32'h0, "alarm flag cleared");
    $display("Test alarm done");
    // Cyclic request every n ticks, then switched off
    wreg(rta_pkg::REG_PERIOD, 32'h0000_0000);
    nc = $urandom_range(4, 2);
    wreg(rta_pkg::REG_CYCLE, nc);
    wreg(rta_pkg::REG_ENABLE, 32'h0000_0002);
    wait_evt(1, 2000, n);
    wait_evt(1, 2000, n);
    check(n, nc * rta_pkg::PRE_DIV, "cyclic period");
    wreg(rta_pkg::REG_CYCLE, 32'h0000_0000);
    wait_evt(1, 600, n);
    check(n, -1, "cyclic off");
    $display("Test cyclic done");
    // Idle stops counting unless run bit set
    wreg(rta_pkg::REG_ENABLE, 32'h0000_0000);
    idleMode <= 1'b1;
    repeat (3) @(posedge core_clk);
    rreg(rta_pkg::REG_COUNT, rd);
    repeat (300) @(posedge core_clk);
    rreg(rta_pkg::REG_COUNT, rd2);
    check(rd2, rd, "idle stop");
    wreg(rta_pkg::REG_CTRL, 32'h0000_0005);
    rreg(rta_pkg::REG_COUNT, rd);
    repeat (256) @(posedge core_clk);
    rreg(rta_pkg::REG_COUNT, rd2);
    check({31'h0, rd2 - rd >= 4 && rd2 - rd <= 5}, 32'h1, "idle run");
    idleMode <= 1'b0;
    $display("Test idle done");
    // Power down: requests, wake and oscillator-off stop
    powerdownMode <= 1'b1;
    wreg(rta_pkg::REG_ENABLE, 32'h0000_0001);
    wait_evt(0, 200, n);
    check({31'h0, n > 0}, 32'h1, "tick in power down");
    wait_evt(3, 200, n);
    check(n, -1, "no wake unconfigured");
    wreg(rta_pkg::REG_CTRL, 32'h0000_000D);
    wait_evt(3, 200, n);
    check({31'h0, n > 0}, 32'h1, "wake");
    wreg(rta_pkg::REG_CTRL, 32'h0000_0007);
    repeat (3) @(posedge core_clk);
    wait_evt(0, 300, n);
    check(n, -1, "osc off stops ticks");
    powerdownMode <= 1'b0;
    $display("Test power down done");
    complete_run();
  end
endmodule : rtc_timekeeper_alarm_tb_top
